//--- verilog/dsad_pkg.sv
// Shared constants and carrier types for the DMA source attribute decoder.
// Assumes a 32-bit AXI4-Lite register bus with 12-bit byte addresses.
`default_nettype none

package dsad_pkg;

  // ********************************************************************
  // register map
  // ********************************************************************
  localparam int          ADDR_W        = 12;
  localparam logic [11:0] SAT_OFF       = 12'h530;
  localparam logic [11:0] STAT_OFF      = 12'h540;
  localparam logic [31:0] SAT_RESET     = 32'h0000_0000;
  localparam logic [31:0] SAT_WR_MASK   = 32'h3300_1FFF;

  // ********************************************************************
  // field positions
  // ********************************************************************
  localparam int TYPE_HI    = 29;
  localparam int TYPE_LO    = 28;
  localparam int PSZ_BIT    = 25;
  localparam int HOLD_BIT   = 24;
  localparam int RATE_HI    = 12;
  localparam int RATE_LO    = 11;
  localparam int KIND_HI    = 10;
  localparam int KIND_LO    = 8;
  localparam int WIDTH_HI   = 7;
  localparam int WIDTH_LO   = 6;
  localparam int SUP_BIT    = 5;
  localparam int PGM_BIT    = 4;
  localparam int SPACE_HI   = 3;
  localparam int SPACE_LO   = 0;

  // ********************************************************************
  // bus answers
  // ********************************************************************
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  // pattern advance per lane in byte mode: four lanes per word
  localparam logic [7:0]  BYTE_STEP  = 8'h04;
  localparam logic [31:0] WORD_STEP  = 32'h0000_0001;

  // ********************************************************************
  // encodings
  // ********************************************************************
  typedef enum logic [1:0] {
    DSAD_SRC_PCI = 2'b00,
    DSAD_SRC_VME = 2'b01,
    DSAD_SRC_PAT = 2'b10
  } dsad_src_t;

  typedef enum logic [1:0] {
    DSAD_W16  = 2'b00,
    DSAD_W32  = 2'b01,
    DSAD_W64  = 2'b10,
    DSAD_WRES = 2'b11
  } dsad_width_t;

  localparam logic [2:0] KIND_SCT  = 3'h0;
  localparam logic [2:0] KIND_BLT  = 3'h1;
  localparam logic [2:0] KIND_BCST = 3'h5;
  localparam logic [1:0] RATE_RES  = 2'h3;
  localparam logic [1:0] USER_HI   = 2'h1;

  typedef struct packed {
    logic [1:0]  fast_sst_rate;
    logic [2:0]  vme_xfer_kind;
    dsad_width_t vme_width_limit;
    logic        privileged_access;
    logic        program_access;
    logic [3:0]  vme_addr_space;
    logic        am_user;
    logic [5:0]  am_code;
  } dsad_vme_cfg_t;

  typedef struct packed {
    logic pattern_byte_size;
    logic pattern_hold;
  } dsad_pat_cfg_t;

endpackage : dsad_pkg

`default_nettype wire

//--- verilog/dsad_top.sv
// Source attribute register of one DMA channel, its decode and the data
// pattern generator that it steers.
// Assumes one clock, a synchronous active-low reset and an AXI4-Lite master.
`timescale 1ns/100ps
`default_nettype none

module dsad_top (
  // clock, reset, enable
  input  wire logic                   aclk,
  input  wire logic                   aresetn,
  input  wire logic                   ce,
  // axi4-lite write address
  input  wire logic                   s_axi_awvalid,
  output var  logic                   s_axi_awready,
  input  wire logic [11:0]            s_axi_awaddr,
  // axi4-lite write data
  input  wire logic                   s_axi_wvalid,
  output var  logic                   s_axi_wready,
  input  wire logic [31:0]            s_axi_wdata,
  input  wire logic [3:0]             s_axi_wstrb,
  // axi4-lite write response
  output var  logic                   s_axi_bvalid,
  input  wire logic                   s_axi_bready,
  output var  logic [1:0]             s_axi_bresp,
  // axi4-lite read address
  input  wire logic                   s_axi_arvalid,
  output var  logic                   s_axi_arready,
  input  wire logic [11:0]            s_axi_araddr,
  // axi4-lite read data
  output var  logic                   s_axi_rvalid,
  input  wire logic                   s_axi_rready,
  output var  logic [31:0]            s_axi_rdata,
  output var  logic [1:0]             s_axi_rresp,
  // descriptor engine
  input  wire logic                   desc_load,
  input  wire logic [31:0]            desc_attr,
  // pattern consumer
  input  wire logic                   pat_start,
  input  wire logic [31:0]            pat_seed,
  input  wire logic                   pat_step,
  output var  logic [31:0]            pattern_word,
  // decoded attributes
  output var  dsad_pkg::dsad_src_t     src_kind,
  output var  dsad_pkg::dsad_vme_cfg_t vme_cfg,
  output var  dsad_pkg::dsad_pat_cfg_t pat_cfg,
  output var  logic                   cfg_fault
);
  default clocking cb_main @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // ********************************************************************
  // write channel state
  // ********************************************************************
  typedef enum logic [1:0] {
    DSAD_WS_IDLE = 2'b00,
    DSAD_WS_ADDR = 2'b01,
    DSAD_WS_DATA = 2'b10,
    DSAD_WS_RESP = 2'b11
  } dsad_wstate_t;

  function automatic logic dsad_hit(input logic [11:0] addr, input logic [11:0] off);
    dsad_hit = (addr[11:2] == off[11:2]);
  endfunction : dsad_hit

  dsad_wstate_t  wstate_reg;
  dsad_wstate_t  wstate_next;
  logic [11:0]   waddr_reg;
  logic [31:0]   wdata_reg;
  logic [3:0]    wstrb_reg;
  logic [31:0]   attr_reg;
  logic [31:0]   attr_next;
  logic [31:0]   status_word;
  logic [31:0]   lane_mask;
  logic [11:0]   waddr_eff;
  logic [31:0]   wdata_eff;
  logic [3:0]    wstrb_eff;
  logic          aw_hs;
  logic          w_hs;
  logic          do_write;
  logic          is_vme;
  logic          is_pat;
  logic          user_grp;
  logic          wide_kind;
  logic [2:0]    kind_f;
  logic [3:0]    space_f;
  logic [31:0]   pattern_step_word;

  assign aw_hs     = s_axi_awvalid && s_axi_awready;
  assign w_hs      = s_axi_wvalid && s_axi_wready;
  assign waddr_eff = aw_hs ? s_axi_awaddr : waddr_reg;
  assign wdata_eff = w_hs ? s_axi_wdata : wdata_reg;
  assign wstrb_eff = w_hs ? s_axi_wstrb : wstrb_reg;

  // ********************************************************************
  // write channel
  // ********************************************************************
  always_comb begin
    wstate_next = wstate_reg;
    unique case (wstate_reg)
      // state codes mirror which of data and address were taken
      DSAD_WS_IDLE: wstate_next = dsad_wstate_t'({w_hs, aw_hs});
      DSAD_WS_ADDR: wstate_next = w_hs ? DSAD_WS_RESP : DSAD_WS_ADDR;
      DSAD_WS_DATA: wstate_next = aw_hs ? DSAD_WS_RESP : DSAD_WS_DATA;
      DSAD_WS_RESP: wstate_next = s_axi_bready ? DSAD_WS_IDLE : DSAD_WS_RESP;
    endcase
  end

  assign do_write = (wstate_reg != DSAD_WS_RESP) && (wstate_next == DSAD_WS_RESP);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wstate_reg    <= DSAD_WS_IDLE;
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
    end else if (ce) begin
      wstate_reg    <= wstate_next;
      s_axi_awready <= (wstate_next == DSAD_WS_IDLE) || (wstate_next == DSAD_WS_DATA);
      s_axi_wready  <= (wstate_next == DSAD_WS_IDLE) || (wstate_next == DSAD_WS_ADDR);
      s_axi_bvalid  <= (wstate_next == DSAD_WS_RESP);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      waddr_reg   <= 12'h000;
      wdata_reg   <= 32'h0000_0000;
      wstrb_reg   <= 4'h0;
      s_axi_bresp <= dsad_pkg::RESP_OKAY;
    end else if (ce) begin
      if (aw_hs) begin
        waddr_reg <= s_axi_awaddr;
      end
      if (w_hs) begin
        wdata_reg <= s_axi_wdata;
        wstrb_reg <= s_axi_wstrb;
      end
      if (do_write) begin
        s_axi_bresp <= dsad_hit(waddr_eff, dsad_pkg::SAT_OFF)  ? dsad_pkg::RESP_OKAY :
                       dsad_hit(waddr_eff, dsad_pkg::STAT_OFF) ? dsad_pkg::RESP_SLVERR :
                       dsad_pkg::RESP_DECERR;
      end
    end
  end

  // ********************************************************************
  // attribute word
  // ********************************************************************
  genvar gl;
  generate
    for (gl = 0; gl < 4; gl++) begin : g_lane
      assign lane_mask[gl*8 +: 8] = {8{wstrb_eff[gl]}};
    end
  endgenerate

  // descriptor wins over a colliding software write: the chain owns the word
  always_comb begin
    attr_next = attr_reg;
    if (desc_load) begin
      attr_next = desc_attr & dsad_pkg::SAT_WR_MASK;
    end else if (do_write && dsad_hit(waddr_eff, dsad_pkg::SAT_OFF)) begin
      attr_next = ((attr_reg & ~lane_mask) | (wdata_eff & lane_mask))
                  & dsad_pkg::SAT_WR_MASK;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      attr_reg <= dsad_pkg::SAT_RESET;
    end else if (ce) begin
      attr_reg <= attr_next;
    end
  end

  // ********************************************************************
  // read channel
  // ********************************************************************
  assign status_word = {27'h000_0000, cfg_fault, vme_cfg.vme_width_limit, src_kind};

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= dsad_pkg::RESP_OKAY;
    end else if (ce) begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        if (dsad_hit(s_axi_araddr, dsad_pkg::SAT_OFF)) begin
          s_axi_rdata <= attr_reg;
          s_axi_rresp <= dsad_pkg::RESP_OKAY;
        end else if (dsad_hit(s_axi_araddr, dsad_pkg::STAT_OFF)) begin
          s_axi_rdata <= status_word;
          s_axi_rresp <= dsad_pkg::RESP_OKAY;
        end else begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= dsad_pkg::RESP_DECERR;
        end
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid  <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

  // ********************************************************************
  // attribute decode
  // ********************************************************************
  assign is_pat    = attr_reg[dsad_pkg::TYPE_HI];
  assign is_vme    = !attr_reg[dsad_pkg::TYPE_HI] && attr_reg[dsad_pkg::TYPE_LO];
  assign kind_f    = attr_reg[dsad_pkg::KIND_HI:dsad_pkg::KIND_LO];
  assign space_f   = attr_reg[dsad_pkg::SPACE_HI:dsad_pkg::SPACE_LO];
  assign user_grp  = (space_f[3:2] == 2'b10);
  assign wide_kind = (kind_f != dsad_pkg::KIND_SCT) && (kind_f != dsad_pkg::KIND_BLT);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      src_kind <= dsad_pkg::DSAD_SRC_PCI;
    end else if (ce) begin
      src_kind <= is_pat ? dsad_pkg::DSAD_SRC_PAT :
                  (is_vme ? dsad_pkg::DSAD_SRC_VME : dsad_pkg::DSAD_SRC_PCI);
    end
  end

  // foreign fields are forced to zero so consumers never see stale settings
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      vme_cfg <= '0;
    end else if (ce) begin
      if (!is_vme) begin
        vme_cfg <= '0;
      end else begin
        vme_cfg.fast_sst_rate     <= attr_reg[dsad_pkg::RATE_HI:dsad_pkg::RATE_LO];
        vme_cfg.vme_xfer_kind     <= kind_f;
        vme_cfg.vme_width_limit   <= wide_kind ? dsad_pkg::DSAD_W64
          : dsad_pkg::dsad_width_t'(attr_reg[dsad_pkg::WIDTH_HI:dsad_pkg::WIDTH_LO]);
        vme_cfg.privileged_access <= attr_reg[dsad_pkg::SUP_BIT];
        vme_cfg.program_access    <= attr_reg[dsad_pkg::PGM_BIT];
        vme_cfg.vme_addr_space    <= space_f;
        vme_cfg.am_user           <= user_grp;
        vme_cfg.am_code           <= {(user_grp ? {dsad_pkg::USER_HI, space_f[1:0]} : 4'h0),
                                      attr_reg[dsad_pkg::SUP_BIT],
                                      attr_reg[dsad_pkg::PGM_BIT]};
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pat_cfg <= '0;
    end else if (ce) begin
      pat_cfg.pattern_byte_size <= is_pat && attr_reg[dsad_pkg::PSZ_BIT];
      pat_cfg.pattern_hold      <= is_pat && attr_reg[dsad_pkg::HOLD_BIT];
    end
  end

  // reserved codes give undefined transfers; flag them for software
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cfg_fault <= 1'b0;
    end else if (ce) begin
      cfg_fault <= is_vme && (
                   (attr_reg[dsad_pkg::RATE_HI:dsad_pkg::RATE_LO] == dsad_pkg::RATE_RES)
                   || (kind_f > dsad_pkg::KIND_BCST)
                   || (!wide_kind && attr_reg[dsad_pkg::WIDTH_HI])
                   || (space_f == 4'h3) || (space_f[3:1] == 3'h3)
                   || (space_f[3:2] == 2'b11));
    end
  end

  // ********************************************************************
  // pattern generator
  // ********************************************************************
  // always a full 32-bit word: byte size changes content, not beat width
  generate
    for (gl = 0; gl < 4; gl++) begin : g_step
      assign pattern_step_word[gl*8 +: 8] = pattern_word[gl*8 +: 8] + dsad_pkg::BYTE_STEP;
    end
  endgenerate

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pattern_word <= 32'h0000_0000;
    end else if (ce && src_kind == dsad_pkg::DSAD_SRC_PAT) begin
      if (pat_start) begin
        pattern_word <= pat_cfg.pattern_byte_size
                        ? {pat_seed[7:0] + 8'h03, pat_seed[7:0] + 8'h02,
                           pat_seed[7:0] + 8'h01, pat_seed[7:0]} : pat_seed;
      end else if (pat_step && !pat_cfg.pattern_hold) begin
        pattern_word <= pat_cfg.pattern_byte_size ? pattern_step_word
                        : pattern_word + dsad_pkg::WORD_STEP;
      end
    end
  end

  // ********************************************************************
  // checks
  // ********************************************************************
  property p_pat_select;
    (ce && attr_reg[dsad_pkg::TYPE_HI]) |=> (src_kind == dsad_pkg::DSAD_SRC_PAT);
  endproperty
  a_pat_select: assert property (p_pat_select) else $error("pattern type not selected");
  property p_vme_gated;
    (ce && !is_vme) |=> (vme_cfg == '0);
  endproperty
  a_vme_gated: assert property (p_vme_gated) else $error("vme fields leak");
  property p_byte_size;
    (ce && is_pat) |=> (pat_cfg.pattern_byte_size == $past(attr_reg[dsad_pkg::PSZ_BIT]));
  endproperty
  a_byte_size: assert property (p_byte_size) else $error("pattern size wrong");
  property p_hold;
    (ce && pat_step && !pat_start && pat_cfg.pattern_hold) |=> $stable(pattern_word);
  endproperty
  a_hold: assert property (p_hold) else $error("held pattern moved");
  property p_rate;
    (ce && is_vme) |=> (vme_cfg.fast_sst_rate == $past(attr_reg[12:11]));
  endproperty
  a_rate: assert property (p_rate) else $error("2eSST rate wrong");
  property p_width64;
    (ce && is_vme && wide_kind) |=> (vme_cfg.vme_width_limit == dsad_pkg::DSAD_W64);
  endproperty
  a_width64: assert property (p_width64) else $error("wide mode not 64-bit");
  property p_width16;
    (ce && is_vme && !wide_kind && attr_reg[7:6] == 2'b00)
      |=> (vme_cfg.vme_width_limit == dsad_pkg::DSAD_W16);
  endproperty
  a_width16: assert property (p_width16) else $error("sct/blt width wrong");
  property p_user_am;
    (ce && is_vme && user_grp)
      |=> (vme_cfg.am_code == {2'b01, $past(attr_reg[1:0]), $past(attr_reg[5]),
                               $past(attr_reg[4])});
  endproperty
  a_user_am: assert property (p_user_am) else $error("user AM code wrong");
  property p_reserved_zero;
    (ce && s_axi_arvalid && s_axi_arready && dsad_hit(s_axi_araddr, dsad_pkg::SAT_OFF))
      |=> (s_axi_rvalid && (s_axi_rdata & ~dsad_pkg::SAT_WR_MASK) == 32'h0000_0000);
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bits set");
  property p_desc_load;
    (ce && desc_load) |=> (attr_reg == ($past(desc_attr) & dsad_pkg::SAT_WR_MASK));
  endproperty
  a_desc_load: assert property (p_desc_load) else $error("descriptor not loaded");

endmodule : dsad_top

`default_nettype wire

//--- test/dsad_consumer.sv
// Pattern consumer model: launches a pattern run and takes words.
// Assumes the bench raises at most one request per cycle.
`timescale 1ns/100ps
`default_nettype none

module dsad_consumer (
  // clock
  input  wire logic        aclk,
  // bench requests
  input  wire logic        start_req,
  input  wire logic        take_req,
  input  wire logic [31:0] seed_req,
  // toward the generator
  output var  logic        pat_start,
  output var  logic        pat_step,
  output var  logic [31:0] pat_seed
);
  // seed means nothing outside the start pulse, so it wobbles there
  always_ff @(posedge aclk) begin
    pat_start <= start_req;
    pat_step  <= take_req;
    pat_seed  <= start_req ? seed_req : ~pat_seed;
  end
endmodule : dsad_consumer

`default_nettype wire

//--- test/dsad_top_bench.sv
// Self-checking bench for the source attribute decoder.
// Assumes a 100 MHz clock and an AXI4-Lite master driven from here.
`timescale 1ns/100ps
`default_nettype none

`define chk(a, b) begin checks++; if ((a) !== (b)) begin n_mismatch++; \
  $display("ERROR %0t: got %h want %h", $time, a, b); end end

module dsad_top_bench;
  logic        aclk = 1'b0, aresetn = 1'b0;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [11:0] awaddr = 12'h000, araddr = 12'h000;
  logic [31:0] wdata = 32'h0, rdata, desc_attr = 32'h0, pat_seed, pattern_word;
  logic [3:0]  wstrb = 4'hF;
  logic [1:0]  bresp, rresp, r;
  logic        desc_load = 1'b0, start_req = 1'b0, take_req = 1'b0, ce = 1'b1;
  logic        pat_start, pat_step, cfg_fault;
  logic [31:0] seed_req = 32'h0, d;
  dsad_pkg::dsad_src_t     src_kind;
  dsad_pkg::dsad_vme_cfg_t vme_cfg;
  dsad_pkg::dsad_pat_cfg_t pat_cfg;
  int          n_mismatch = 0, checks = 0;

  always #5 aclk = ~aclk;

  dsad_top i_dsad_top (.aclk(aclk), .aresetn(aresetn), .ce(ce),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_awaddr(awaddr),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_bresp(bresp),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_araddr(araddr),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .desc_load(desc_load), .desc_attr(desc_attr), .pat_start(pat_start),
    .pat_seed(pat_seed), .pat_step(pat_step), .pattern_word(pattern_word),
    .src_kind(src_kind), .vme_cfg(vme_cfg), .pat_cfg(pat_cfg), .cfg_fault(cfg_fault));

  dsad_consumer i_dsad_consumer (.aclk(aclk), .start_req(start_req), .take_req(take_req),
    .seed_req(seed_req), .pat_start(pat_start), .pat_step(pat_step), .pat_seed(pat_seed));

  // ********************************************************************
  // bus cycles
  // ********************************************************************
  task automatic axi_write(input logic [11:0] a, input logic [31:0] v, input logic [3:0] s);
    @(posedge aclk);
    awvalid <= 1'b1;
    awaddr  <= a;
    wvalid  <= 1'b1;
    wdata   <= v;
    wstrb   <= s;
    bready  <= 1'b1;
    // the watchdog ends a hang here
    forever begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bready && bvalid) begin
        r = bresp;
        bready <= 1'b0;
        break;
      end
    end
    // decoded outputs trail the stored word by one edge
    repeat (2) @(posedge aclk);
  endtask : axi_write

  task automatic axi_read(input logic [11:0] a);
    @(posedge aclk);
    arvalid <= 1'b1;
    araddr  <= a;
    rready  <= 1'b1;
    forever begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rready && rvalid) begin
        d = rdata;
        r = rresp;
        rready <= 1'b0;
        break;
      end
    end
  endtask : axi_read

  // start (s=1) or step (s=0) through the consumer, then let the word settle
  task automatic pulse(input bit s, input logic [31:0] seed);
    @(posedge aclk);
    if (s) start_req <= 1'b1; else take_req <= 1'b1;
    seed_req <= seed;
    @(posedge aclk);
    start_req <= 1'b0;
    take_req  <= 1'b0;
    repeat (2) @(posedge aclk);
  endtask : pulse

  function automatic dsad_pkg::dsad_vme_cfg_t vme_want(input logic [31:0] w);
    dsad_pkg::dsad_vme_cfg_t c;
    c.fast_sst_rate     = w[12:11];
    c.vme_xfer_kind     = w[10:8];
    c.vme_width_limit   = (w[10:8] < 3'h2) ? dsad_pkg::dsad_width_t'(w[7:6])
                                           : dsad_pkg::DSAD_W64;
    c.privileged_access = w[5];
    c.program_access    = w[4];
    c.vme_addr_space    = w[3:0];
    c.am_user           = (w[3:2] == 2'h2);
    c.am_code           = c.am_user ? {2'h1, w[1:0], w[5], w[4]} : {4'h0, w[5], w[4]};
    return c;
  endfunction : vme_want

  // ********************************************************************
  // scenarios
  // ********************************************************************
  task automatic t_regs();
    axi_read(12'h530);
    `chk(d, 32'h0000_0000)
    `chk(src_kind, dsad_pkg::DSAD_SRC_PCI)
    axi_write(12'h530, 32'hFFFF_FFFF, 4'hF);
    axi_read(12'h530);
    `chk(d, 32'h3300_1FFF)
    `chk(src_kind, dsad_pkg::DSAD_SRC_PAT)
    `chk(vme_cfg, 20'h0)
    axi_write(12'h530, 32'h0, 4'h1);
    axi_read(12'h530);
    `chk(d, 32'h3300_1F00)
    $display("regs done");
  endtask : t_regs

  task automatic t_vme();
    // legal codes only: reserved codes stay out of this table's software writes
    logic [31:0] tbl [6] = '{32'h1000_0148, 32'h1300_0AFB, 32'h1000_1432,
                            32'h1000_0510, 32'h1000_0015, 32'h1000_0304};
    dsad_pkg::dsad_vme_cfg_t w;
    logic [31:0]             st;
    foreach (tbl[i]) begin
      axi_write(12'h530, tbl[i], 4'hF);
      w  = vme_want(tbl[i]);
      st = {27'h0, 1'b0, w.vme_width_limit, 2'h1};
      `chk(src_kind, dsad_pkg::DSAD_SRC_VME)
      `chk(vme_cfg, w)
      `chk(pat_cfg, 2'h0)
      axi_read(12'h540);
      `chk(d, st)
    end
    $display("vme done");
  endtask : t_vme

  task automatic t_pattern();
    axi_write(12'h530, 32'h2200_0000, 4'hF);
    `chk(pat_cfg, 2'h2)
    pulse(1'b1, 32'hAAAA_AA10);
    `chk(pattern_word, 32'h1312_1110)
    pulse(1'b0, 32'h0);
    `chk(pattern_word, 32'h1716_1514)
    axi_write(12'h530, 32'h3300_0000, 4'hF);
    `chk(src_kind, dsad_pkg::DSAD_SRC_PAT)
    pulse(1'b0, 32'h0);
    `chk(pattern_word, 32'h1716_1514)
    axi_write(12'h530, 32'h2000_0000, 4'hF);
    pulse(1'b1, 32'hFFFF_FFFE);
    pulse(1'b0, 32'h0);
    `chk(pattern_word, 32'hFFFF_FFFF)
    // a step offered while the enable is low must be lost
    ce <= 1'b0;
    pulse(1'b0, 32'h0);
    ce <= 1'b1;
    `chk(pattern_word, 32'hFFFF_FFFF)
    axi_write(12'h530, 32'h0, 4'hF);
    pulse(1'b1, 32'h5);
    `chk(pattern_word, 32'hFFFF_FFFF)
    $display("pattern done");
  endtask : t_pattern

  task automatic t_desc_err();
    @(posedge aclk);
    desc_load <= 1'b1;
    desc_attr <= 32'hFFFF_E14A;
    @(posedge aclk);
    desc_load <= 1'b0;
    repeat (2) @(posedge aclk);
    axi_read(12'h530);
    `chk(d, 32'h3300_014A)
    axi_read(12'h7FC);
    `chk(r, dsad_pkg::RESP_DECERR)
    `chk(d, 32'h0)
    axi_write(12'h540, 32'h0, 4'hF);
    `chk(r, dsad_pkg::RESP_SLVERR)
    // rate 11 is reserved: the decoder must raise its fault flag
    axi_write(12'h530, 32'h1000_1800, 4'hF);
    `chk(cfg_fault, 1'b1)
    axi_read(12'h540);
    `chk(d, 32'h0000_0011)
    $display("descriptor and errors done");
  endtask : t_desc_err

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : print_verdict

  initial begin
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    t_regs();
    t_vme();
    t_pattern();
    t_desc_err();
    print_verdict();
  end

  // the whole run needs well under a thousand cycles
  initial begin
    repeat (5000) @(posedge aclk);
    n_mismatch++;
    print_verdict();
  end
endmodule : dsad_top_bench

`default_nettype wire
